// ==== rtl/pfsw_pkg.sv ====
`default_nettype none
package pfsw_pkg;
   // Array geometry
   localparam int ADDR_W = 13;
   localparam int DATA_W = 14;
   localparam int FLASH_WORDS = 8192;
   localparam int LATCHES = 8;
   localparam int LAT_IDX_W = 3;
   localparam int ROW_WORDS = 32;
   localparam int ROW_IDX_W = 5;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_KEY = 8'h04;
   localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
   localparam logic [7:0] OFF_ADDR_HIGH = 8'h0C;
   localparam logic [7:0] OFF_DATA_LOW = 8'h10;
   localparam logic [7:0] OFF_DATA_HIGH = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   // Control register bit positions
   localparam int CTRL_START = 0;
   localparam int CTRL_WRITE_ENABLE_BIT = 2;
   localparam int CTRL_ROW_ERASE = 4;
   localparam int CTRL_LATCH_ONLY = 5;
   localparam int CTRL_CFG_SPACE = 6;
   localparam int CTRL_PGM_SPACE = 7;

   // Status register bit positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_STALL = 1;
   localparam int STAT_KEY_FIRST = 2;
   localparam int STAT_KEY_ARMED = 3;

   // Unlock key bytes and erased value
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [DATA_W-1:0] ERASED_WORD = 14'h3FFF;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETUP_CYCLES = 2;
   localparam int ERASE_TIME_MS = 2;
   localparam int WRITE_TIME_MS = 2;
   localparam int ERASE_CYCLES_DFLT = (ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int WRITE_CYCLES_DFLT = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_RUN = 2'b10,
      ST_WAIT = 2'b11
   } pfsw_state_type;

   typedef enum logic [1:0] {
      KEY_NONE = 2'b00,
      KEY_GOT_FIRST = 2'b01,
      KEY_ARMED = 2'b10
   } pfsw_key_type;
endpackage : pfsw_pkg
`default_nettype wire

// ==== rtl/pfsw_flash_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface pfsw_flash_if;
   import pfsw_pkg::*;
   logic ld_en;
   logic [LAT_IDX_W-1:0] ld_idx;
   logic [DATA_W-1:0] ld_data;
   logic lat_clr;
   logic [DATA_W-1:0] lat_word [LATCHES];
   logic erase_go;
   logic prog_go;
   logic [ADDR_W-1:0] op_addr;
   logic op_done;

   modport ctrl (output ld_en, ld_idx, ld_data, erase_go, prog_go, op_addr, input op_done);
   modport latch (input ld_en, ld_idx, ld_data, lat_clr, output lat_word);
   modport array (input erase_go, prog_go, op_addr, lat_word, output op_done, lat_clr);
endinterface : pfsw_flash_if
`default_nettype wire

// ==== rtl/pfsw_latches.sv ====
`timescale 1ns/10ps
`default_nettype none
module pfsw_latches
   import pfsw_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Latch side of the flash link
   pfsw_flash_if.latch fl
);
   genvar i;
   generate
      for (i = 0; i < LATCHES; i++) begin : g_latch
         logic [DATA_W-1:0] word_q;
         always_ff @(posedge mclk) begin
            if (rst || fl.lat_clr) begin
               word_q <= ERASED_WORD;
            end else if (fl.ld_en && fl.ld_idx == LAT_IDX_W'(i)) begin
               word_q <= fl.ld_data;
            end
         end
         assign fl.lat_word[i] = word_q;
      end
   endgenerate
endmodule : pfsw_latches
`default_nettype wire

// ==== rtl/pfsw_array.sv ====
`timescale 1ns/10ps
`default_nettype none
module pfsw_array
   import pfsw_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DFLT,
   parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Array side of the flash link
   pfsw_flash_if.array fl
);
   logic [DATA_W-1:0] mem [FLASH_WORDS];
   logic [31:0] cnt_q;
   logic busy_q;
   logic erase_q;
   logic [ADDR_W-1:0] addr_q;
   logic finish;

   assign finish = busy_q && cnt_q == 32'h0000_0000;

   always_ff @(posedge mclk) begin
      if (rst) begin
         busy_q <= 1'b0;
         erase_q <= 1'b0;
         cnt_q <= 32'h0000_0000;
         addr_q <= '0;
      end else if (!busy_q && (fl.erase_go || fl.prog_go)) begin
         busy_q <= 1'b1;
         erase_q <= fl.erase_go;
         addr_q <= fl.op_addr;
         cnt_q <= fl.erase_go ? ERASE_CYCLES - 32'd1 : WRITE_CYCLES - 32'd1;
      end else if (finish) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 32'd1;
      end
   end

   // Whole row erase or whole latch block program
   always_ff @(posedge mclk) begin
      if (finish) begin
         if (erase_q) begin
            for (int r = 0; r < ROW_WORDS; r++) begin
               mem[{addr_q[ADDR_W-1:ROW_IDX_W], ROW_IDX_W'(r)}] <= ERASED_WORD;
            end
         end else begin
            for (int w = 0; w < LATCHES; w++) begin
               // Programming only clears bits; no implicit erase
               mem[{addr_q[ADDR_W-1:LAT_IDX_W], LAT_IDX_W'(w)}] <=
                  mem[{addr_q[ADDR_W-1:LAT_IDX_W], LAT_IDX_W'(w)}] & fl.lat_word[w];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         fl.op_done <= 1'b0;
         fl.lat_clr <= 1'b0;
      end else begin
         fl.op_done <= finish;
         fl.lat_clr <= finish && !erase_q;
      end
   end
endmodule : pfsw_array
`default_nettype wire

// ==== rtl/pfsw_top.sv ====
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pfsw_top
   import pfsw_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DFLT,
   parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DFLT
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor execution control
   output logic cpu_stall,
   output logic cpu_resume
);
   pfsw_flash_if fl ();

   pfsw_latches u_latches (
      .mclk(mclk),
      .rst(rst),
      .fl(fl.latch)
   );

   pfsw_array #(
      .ERASE_CYCLES(ERASE_CYCLES),
      .WRITE_CYCLES(WRITE_CYCLES)
   ) u_array (
      .mclk(mclk),
      .rst(rst),
      .fl(fl.array)
   );

   // Bus handshake
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic access;
   logic wr_take;
   logic [31:0] rd_val;
   logic hit;

   // Register state
   logic start_q;
   logic write_enable_bit_q;
   logic row_erase_q;
   logic latches_only_select_q;
   logic config_space_select_q;
   logic program_space_select_q;
   logic [7:0] flash_addr_low_q;
   logic [7:0] flash_addr_high_q;
   logic [7:0] flash_data_low_q;
   logic [7:0] flash_data_high_q;
   pfsw_key_type key_q;
   pfsw_state_type state_q;
   logic [1:0] setup_cnt_q;
   logic stall_q;
   logic resume_q;
   logic ld_en_q;
   logic erase_go_q;
   logic prog_go_q;

   // Decoded write events
   logic wr_ctrl;
   logic wr_key;
   logic start_req;
   logic launch;
   logic busy;
   logic [ADDR_W-1:0] full_addr;

   assign access = psel && penable && !pready_q;
   assign wr_take = psel && penable && pready_q && pwrite;
   assign wr_ctrl = wr_take && paddr == OFF_CTRL;
   assign wr_key = wr_take && paddr == OFF_KEY;
   assign busy = state_q != ST_IDLE;
   assign full_addr = ADDR_W'({flash_addr_high_q, flash_addr_low_q});
   assign start_req = wr_ctrl && pwdata[CTRL_START];
   assign launch = start_req && key_q == KEY_ARMED && !busy && pwdata[CTRL_WRITE_ENABLE_BIT]
                   && pwdata[CTRL_PGM_SPACE] && !pwdata[CTRL_CFG_SPACE];

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;
   assign cpu_stall = stall_q;
   assign cpu_resume = resume_q;

   assign fl.ld_en = ld_en_q;
   assign fl.ld_idx = full_addr[LAT_IDX_W-1:0];
   assign fl.ld_data = {flash_data_high_q[DATA_W-9:0], flash_data_low_q};
   assign fl.erase_go = erase_go_q;
   assign fl.prog_go = prog_go_q;
   assign fl.op_addr = full_addr;

   // Read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      hit = 1'b1;
      unique case (paddr)
         OFF_CTRL: begin
            rd_val[CTRL_START] = start_q;
            rd_val[CTRL_WRITE_ENABLE_BIT] = write_enable_bit_q;
            rd_val[CTRL_ROW_ERASE] = row_erase_q;
            rd_val[CTRL_LATCH_ONLY] = latches_only_select_q;
            rd_val[CTRL_CFG_SPACE] = config_space_select_q;
            rd_val[CTRL_PGM_SPACE] = program_space_select_q;
         end
         OFF_KEY: rd_val = 32'h0000_0000;
         OFF_ADDR_LOW: rd_val[7:0] = flash_addr_low_q;
         OFF_ADDR_HIGH: rd_val[7:0] = flash_addr_high_q;
         OFF_DATA_LOW: rd_val[7:0] = flash_data_low_q;
         OFF_DATA_HIGH: rd_val[7:0] = flash_data_high_q;
         OFF_STATUS: begin
            rd_val[STAT_BUSY] = busy;
            rd_val[STAT_STALL] = stall_q;
            rd_val[STAT_KEY_FIRST] = key_q == KEY_GOT_FIRST;
            rd_val[STAT_KEY_ARMED] = key_q == KEY_ARMED;
         end
         default: hit = 1'b0;
      endcase
   end

   // One wait state, then ready for one cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= access;
         pslverr_q <= access && !hit;
         prdata_q <= (access && !pwrite) ? rd_val : 32'h0000_0000;
      end
   end

   // Address and data byte registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         flash_addr_low_q <= BYTE_RST;
         flash_addr_high_q <= BYTE_RST;
         flash_data_low_q <= BYTE_RST;
         flash_data_high_q <= BYTE_RST;
      end else if (wr_take) begin
         if (paddr == OFF_ADDR_LOW) begin
            flash_addr_low_q <= pwdata[7:0];
         end
         if (paddr == OFF_ADDR_HIGH) begin
            flash_addr_high_q <= {3'h0, pwdata[4:0]};
         end
         if (paddr == OFF_DATA_LOW) begin
            flash_data_low_q <= pwdata[7:0];
         end
         if (paddr == OFF_DATA_HIGH) begin
            flash_data_high_q <= {2'h0, pwdata[5:0]};
         end
      end
   end

   // Unlock key: any other write breaks the sequence
   always_ff @(posedge mclk) begin
      if (rst) begin
         key_q <= KEY_NONE;
      end else if (wr_key) begin
         if (pwdata[7:0] == KEY_FIRST) begin
            key_q <= KEY_GOT_FIRST;
         end else if (pwdata[7:0] == KEY_SECOND && key_q == KEY_GOT_FIRST) begin
            key_q <= KEY_ARMED;
         end else begin
            key_q <= KEY_NONE;
         end
      end else if (wr_take) begin
         key_q <= KEY_NONE;
      end
   end

   // Control register; frozen while an operation runs
   always_ff @(posedge mclk) begin
      if (rst) begin
         start_q <= CTRL_RST[CTRL_START];
         write_enable_bit_q <= CTRL_RST[CTRL_WRITE_ENABLE_BIT];
         row_erase_q <= CTRL_RST[CTRL_ROW_ERASE];
         latches_only_select_q <= CTRL_RST[CTRL_LATCH_ONLY];
         config_space_select_q <= CTRL_RST[CTRL_CFG_SPACE];
         program_space_select_q <= CTRL_RST[CTRL_PGM_SPACE];
      end else if (fl.op_done) begin
         start_q <= 1'b0;
         row_erase_q <= 1'b0;
      end else if (wr_ctrl && !busy) begin
         write_enable_bit_q <= pwdata[CTRL_WRITE_ENABLE_BIT];
         row_erase_q <= pwdata[CTRL_ROW_ERASE];
         latches_only_select_q <= pwdata[CTRL_LATCH_ONLY];
         config_space_select_q <= pwdata[CTRL_CFG_SPACE];
         program_space_select_q <= pwdata[CTRL_PGM_SPACE];
         // Latch-only loads finish at once, start never reads back set
         start_q <= launch && (pwdata[CTRL_ROW_ERASE] || !pwdata[CTRL_LATCH_ONLY]);
      end
   end

   // Latch load on every launched non-erase start
   always_ff @(posedge mclk) begin
      if (rst) begin
         ld_en_q <= 1'b0;
      end else begin
         ld_en_q <= launch && !pwdata[CTRL_ROW_ERASE];
      end
   end

   // Operation sequencer
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         setup_cnt_q <= 2'h0;
         erase_go_q <= 1'b0;
         prog_go_q <= 1'b0;
      end else begin
         erase_go_q <= 1'b0;
         prog_go_q <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (launch && (pwdata[CTRL_ROW_ERASE] || !pwdata[CTRL_LATCH_ONLY])) begin
                  state_q <= ST_SETUP;
                  setup_cnt_q <= 2'(SETUP_CYCLES - 1);
               end
            end
            ST_SETUP: begin
               if (setup_cnt_q == 2'h0) begin
                  state_q <= ST_RUN;
               end else begin
                  setup_cnt_q <= setup_cnt_q - 2'h1;
               end
            end
            ST_RUN: begin
               erase_go_q <= row_erase_q;
               prog_go_q <= !row_erase_q;
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               if (fl.op_done) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Stall from end of setup until the array finishes
   always_ff @(posedge mclk) begin
      if (rst) begin
         stall_q <= 1'b0;
         resume_q <= 1'b0;
      end else begin
         resume_q <= fl.op_done;
         if (state_q == ST_SETUP && setup_cnt_q == 2'h0) begin
            stall_q <= 1'b1;
         end else if (fl.op_done) begin
            stall_q <= 1'b0;
         end
      end
   end
endmodule : pfsw_top
`default_nettype wire

// ==== dv/pfsw_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module pfsw_props
   import pfsw_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES = 20,
   parameter int unsigned WRITE_CYCLES = 20
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Execution control
   input wire logic cpu_stall,
   input wire logic cpu_resume
);
   localparam int MIN_ST = (ERASE_CYCLES < WRITE_CYCLES) ? ERASE_CYCLES : WRITE_CYCLES;
   localparam int MAX_ST = ((ERASE_CYCLES > WRITE_CYCLES) ? ERASE_CYCLES : WRITE_CYCLES) + 4;
   logic [31:0] stall_cnt_q;
   logic ctrl_acc;
   logic launch_acc;
   assign ctrl_acc = psel && penable && pready && paddr == OFF_CTRL;
   assign launch_acc = ctrl_acc && pwrite && pwdata[CTRL_START] && pwdata[CTRL_WRITE_ENABLE_BIT];
   always_ff @(posedge mclk) begin
      stall_cnt_q <= (rst || !cpu_stall) ? 32'h0 : stall_cnt_q + 32'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_ready_wait: assert property ((psel && !penable) |-> ##2 pready)
      else $error("pready not two cycles after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_resp_idle: assert property ((pslverr || prdata != 32'h0) |-> pready)
      else $error("response outside ready cycle");
   chk_stall_setup: assert property ($rose(cpu_stall) |->
      $past(launch_acc, 3))
      else $error("stall not three edges after launch");
   chk_stall_time: assert property ($fell(cpu_stall) |->
      (stall_cnt_q >= MIN_ST && stall_cnt_q <= MAX_ST))
      else $error("stall length wrong");
   chk_resume_end: assert property (cpu_resume |-> $fell(cpu_stall))
      else $error("resume without stall end");
   chk_latch_calm: assert property ((ctrl_acc && pwrite && pwdata[CTRL_LATCH_ONLY] &&
      !pwdata[CTRL_ROW_ERASE] && !cpu_stall && !$past(pready, 3)) |=> !cpu_stall [*6])
      else $error("latch load stalled");
   chk_busy_read: assert property ((ctrl_acc && !pwrite && cpu_stall) |->
      prdata[CTRL_START])
      else $error("start bit clear while busy");
   chk_key_zero: assert property ((psel && pready && !pwrite && paddr == OFF_KEY) |->
      prdata == 32'h0)
      else $error("key register read not zero");
   cov_stall: cover property ($rose(cpu_stall));
   cov_resume: cover property (cpu_resume);
   cov_err: cover property (pslverr);
endmodule : pfsw_props
bind pfsw_top pfsw_props #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_pfsw_props (
   .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cpu_stall(cpu_stall), .cpu_resume(cpu_resume));
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import pfsw_pkg::*;
;
   localparam int unsigned N_OP = 20;
   typedef struct {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic e;
   } pfsw_row_type;
   logic mclk = 1'b0;
   logic rst, psel, penable, pwrite, pready, pslverr, cpu_stall, cpu_resume, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int n_errors, num_checks;
   pfsw_row_type rows [6] = '{
      '{OFF_ADDR_LOW, 32'hFFFFFFFF, 32'h000000FF, 1'b0},
      '{OFF_ADDR_HIGH, 32'hFFFFFFFF, 32'h0000001F, 1'b0},
      '{OFF_DATA_LOW, 32'hFFFFFFFF, 32'h000000FF, 1'b0},
      '{OFF_DATA_HIGH, 32'hFFFFFFFF, 32'h0000003F, 1'b0},
      '{OFF_KEY, 32'h00000012, 32'h00000000, 1'b0},
      '{8'h1C, 32'hFFFFFFFF, 32'h00000000, 1'b1}};
   logic [23:0] bad [4] = '{24'h55AA91, 24'h55AAD5, 24'hAA5595, 24'h55AA15};

   pfsw_top #(.ERASE_CYCLES(N_OP), .WRITE_CYCLES(N_OP)) u_pfsw_top (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_stall(cpu_stall), .cpu_resume(cpu_resume));

   always #5 mclk = ~mclk;

   task test_done;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(n < 20, 1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc

   task launch(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
      apb(1'b1, OFF_KEY, {24'h0, k1});
      apb(1'b1, OFF_KEY, {24'h0, k2});
      apb(1'b1, OFF_CTRL, {24'h0, c});
   endtask : launch

   task calm;
      repeat (6) begin
         @(posedge mclk);
         chk(cpu_stall, 1'b0);
      end
   endtask : calm

   task op_run(input logic [31:0] c, input logic [31:0] fin);
      int n;
      launch(8'h55, 8'hAA, c[7:0]);
      n = 1;
      do begin
         @(posedge mclk);
         n++;
      end while (cpu_stall !== 1'b1 && n < 20);
      chk(n, 3);
      rdc(OFF_CTRL, c);
      rdc(OFF_STATUS, 32'h3);
      apb(1'b1, OFF_CTRL, 32'h0);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (cpu_stall === 1'b1 && n < 200);
      chk(cpu_resume, 1'b1);
      rdc(OFF_CTRL, fin);
   endtask : op_run

   initial begin
      #100000;
      n_errors++;
      test_done;
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_errors = 0;
      num_checks = 0;
      repeat (4) @(posedge mclk);
      chk({pready, pslverr, cpu_stall, cpu_resume}, 4'h0);
      rst <= 1'b0;
      @(posedge mclk);
      rdc(OFF_CTRL, 32'h0);
      rdc(OFF_STATUS, 32'h0);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         chk(er, rows[i].e);
         rdc(rows[i].a, rows[i].q);
         chk(er, rows[i].e);
      end
      apb(1'b1, OFF_KEY, 32'h55);
      rdc(OFF_STATUS, 32'h4);
      apb(1'b1, OFF_KEY, 32'hAA);
      rdc(OFF_STATUS, 32'h8);
      apb(1'b1, OFF_ADDR_LOW, 32'h40);
      rdc(OFF_STATUS, 32'h0);
      foreach (bad[i]) begin
         launch(bad[i][23:16], bad[i][15:8], bad[i][7:0]);
         calm;
         rdc(OFF_STATUS, 32'h0);
      end
      apb(1'b1, OFF_ADDR_HIGH, 32'h0);
      op_run(32'h95, 32'h84);
      apb(1'b1, OFF_DATA_LOW, 32'h34);
      apb(1'b1, OFF_DATA_HIGH, 32'h12);
      launch(8'h55, 8'hAA, 8'hA5);
      calm;
      rdc(OFF_CTRL, 32'hA4);
      apb(1'b1, OFF_ADDR_LOW, 32'h41);
      op_run(32'h85, 32'h84);
      test_done;
   end
endmodule : tb_top
`default_nettype wire
